// File: pts_pkg.sv
// Package: register map, field layout and constants for the time sync stamper
package pts_pkg;
  // Register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] PTS_TIME_LOW_OFS = 8'h00;    // system_time_low
  localparam logic [7:0] PTS_TIME_HIGH_OFS = 8'h04;   // system_time_high
  localparam logic [7:0] PTS_INC_CTRL_OFS = 8'h08;    // time_increment_control
  localparam logic [7:0] PTS_OFS_LOW_OFS = 8'h0c;     // time_offset_low
  localparam logic [7:0] PTS_OFS_HIGH_OFS = 8'h10;    // time_offset_high
  localparam logic [7:0] PTS_TS_CTRL_OFS = 8'h14;     // Timestamp control
  localparam logic [7:0] PTS_TX_TS_LOW_OFS = 8'h18;   // Tx stamp low
  localparam logic [7:0] PTS_TX_TS_HIGH_OFS = 8'h1c;  // Tx stamp high, clears tx lock
  localparam logic [7:0] PTS_RX_TS_LOW_OFS = 8'h20;   // Rx stamp low
  localparam logic [7:0] PTS_RX_TS_HIGH_OFS = 8'h24;  // Rx stamp high, clears rx lock
  localparam logic [7:0] PTS_RX_SRC_LOW_OFS = 8'h28;  // Rx source uuid low word
  localparam logic [7:0] PTS_RX_SRC_HIGH_OFS = 8'h2c; // Uuid high 16, seq id 16
  localparam logic [7:0] PTS_STATUS_OFS = 8'h30;      // Lock and duplex status
  // Increment control fields
  localparam int PTS_INC_VALUE_LSB = 0;
  localparam int PTS_INC_VALUE_W = 24;
  localparam int PTS_INC_PERIOD_LSB = 24;
  localparam int PTS_INC_PERIOD_W = 8;
  localparam logic [31:0] PTS_INC_CTRL_RST = 32'h0000_0000;
  // Timestamp control fields
  localparam int PTS_CTL_TX_EN = 0;
  localparam int PTS_CTL_RX_EN = 1;
  localparam int PTS_CTL_V2 = 2;
  localparam int PTS_CTL_MSG_LSB = 8;
  // Status fields
  localparam int PTS_ST_TX_LOCK = 0;
  localparam int PTS_ST_RX_LOCK = 1;
  localparam int PTS_ST_ACTIVE = 2;
  // Receive packet kind for ethertype-matched PTP frames
  localparam logic [3:0] PTS_KIND_PTP_L2 = 4'he;
  localparam logic [3:0] PTS_KIND_NONE = 4'h0;
  // UDP ports for PTP, used only to classify
  localparam logic [15:0] PTS_UDP_EVENT_PORT = 16'd319;
  localparam logic [15:0] PTS_UDP_GENERAL_PORT = 16'd320;
  // Header byte offsets
  localparam logic [5:0] PTS_HDR_MSGID_OFS = 6'd0;
  localparam logic [5:0] PTS_HDR_VER_OFS = 6'd1;
  localparam logic [5:0] PTS_HDR_SRC_FIRST = 6'd22;
  localparam logic [5:0] PTS_HDR_SEQ_HI = 6'd30;
  localparam logic [5:0] PTS_HDR_SEQ_LO = 6'd31;
  localparam logic [5:0] PTS_HDR_CTRL_OFS = 6'd32;
  // V2 path delay message ids, stamped whatever the configured type when the V2 control bit is set
  localparam logic [3:0] PTS_V2_PDLY_REQ = 4'h2;
  localparam logic [3:0] PTS_V2_PDLY_RESP = 4'h3;
  // Clock rate
  localparam int PTS_CLK_HZ = 20_000_000;
endpackage

// File: pts_stamper.sv
// Time sync stamper: system time counter, offset adjust, tx and rx capture
module pts_stamper
  import pts_pkg::*;
(
  input wire logic clk_i,                 // Free running clock, never gated
  input wire logic rst_i,                 // MAC reset, synchronous
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic full_duplex_i,         // Link duplex state
  input wire logic tx_sof_i,              // Tx frame start at the PHY edge
  input wire logic timestamp_request_bit_i, // From descriptor extended command
  input wire logic rx_sof_i,              // Rx frame start at the PHY edge
  input wire logic rx_l2_ptp_i,           // Ethertype filter hit
  input wire logic [15:0] rx_udp_port_i,  // Destination port, 0 if not UDP
  input wire logic rx_byte_valid_i,       // One PTP header byte
  input wire logic [7:0] rx_byte_i,
  input wire logic rx_eof_i,              // End of frame
  output logic rx_desc_valid_o,           // Descriptor indications valid, pulse
  output logic rx_ptp_ind_o,
  output logic [3:0] rx_packet_kind_field_o,
  output logic timestamp_taken_bit_o
);
  import pts_pkg::*;

  // Software visible state, plus the increment divider counter
  logic [63:0] system_time_value_reg;     // Running time
  logic [31:0] time_increment_control_reg;
  logic [31:0] time_offset_low_reg;
  logic [31:0] ts_ctrl_reg;
  logic [31:0] high_latch_reg;            // Snapshot for the high read
  logic [7:0] inc_cnt_reg;                // Increment period divider
  logic [63:0] tx_ts_reg;
  logic [63:0] rx_ts_reg;
  logic [47:0] rx_src_reg;
  logic [15:0] rx_seq_reg;
  logic tx_lock_reg;
  logic rx_lock_reg;
  // Rx frame parse state
  logic [63:0] rx_sof_time_reg;           // Time at frame start
  logic [5:0] rx_pos_reg;
  logic rx_is_ptp_reg;
  logic rx_l2_reg;
  logic rx_v2_reg;
  logic [7:0] rx_msgid_reg;
  logic [7:0] rx_ctrl_reg;
  logic [47:0] rx_src_cap_reg;
  logic [15:0] rx_seq_cap_reg;

  // Bus decode
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign wb_rd = wb_req && !wb_we_i;

  // Sync only works on a full duplex link
  logic ts_active;
  assign ts_active = full_duplex_i;
  logic tx_en;
  logic rx_en;
  assign tx_en = ts_ctrl_reg[PTS_CTL_TX_EN] && ts_active;
  assign rx_en = ts_ctrl_reg[PTS_CTL_RX_EN] && ts_active;

  // Increment divider; period 0 treated as 1 so time still moves
  logic [7:0] inc_period;
  logic inc_event;
  assign inc_period = time_increment_control_reg[PTS_INC_PERIOD_LSB +: PTS_INC_PERIOD_W];
  assign inc_event = (inc_cnt_reg + 8'h01 >= inc_period);

  // Divider counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      inc_cnt_reg <= 8'h00;
    end else if (inc_event) begin
      inc_cnt_reg <= 8'h00;
    end else begin
      inc_cnt_reg <= inc_cnt_reg + 8'h01;
    end
  end

  // System time: offset add beats the increment; sum wraps silently
  logic [63:0] offset_signed;
  logic [63:0] inc_ext;
  assign offset_signed = wb_dat_i[31] ?
    (64'h0 - {1'b0, wb_dat_i[30:0], time_offset_low_reg}) :
    {1'b0, wb_dat_i[30:0], time_offset_low_reg};
  assign inc_ext = {40'h0, time_increment_control_reg[PTS_INC_VALUE_LSB +: PTS_INC_VALUE_W]};

  // Time counter on the ungated clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      system_time_value_reg <= 64'h0;
    end else if (wb_wr && wb_adr_i == PTS_TIME_LOW_OFS) begin
      system_time_value_reg[31:0] <= wb_dat_i;
    end else if (wb_wr && wb_adr_i == PTS_TIME_HIGH_OFS) begin
      system_time_value_reg[63:32] <= wb_dat_i;
    end else if (wb_wr && wb_adr_i == PTS_OFS_HIGH_OFS) begin
      system_time_value_reg <= system_time_value_reg + offset_signed;
    end else if (inc_event) begin
      system_time_value_reg <= system_time_value_reg + inc_ext;
    end
  end

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      time_increment_control_reg <= PTS_INC_CTRL_RST;
      time_offset_low_reg <= 32'h0;
      ts_ctrl_reg <= 32'h0;
    end else if (wb_wr) begin
      unique case (wb_adr_i)
        PTS_INC_CTRL_OFS: time_increment_control_reg <= wb_dat_i;
        PTS_OFS_LOW_OFS: time_offset_low_reg <= wb_dat_i;
        PTS_TS_CTRL_OFS: ts_ctrl_reg <= {16'h0, wb_dat_i[15:8], 5'h0, wb_dat_i[2:0]};
        default: ;
      endcase
    end
  end

  // High half snapshot taken on every low read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_latch_reg <= 32'h0;
    end else if (wb_rd && wb_adr_i == PTS_TIME_LOW_OFS) begin
      high_latch_reg <= system_time_value_reg[63:32];
    end
  end

  // Tx capture at frame start, locked until the high word is read
  logic tx_cap;
  logic tx_rel;
  assign tx_cap = tx_sof_i && timestamp_request_bit_i && tx_en && !tx_lock_reg;
  assign tx_rel = wb_rd && wb_adr_i == PTS_TX_TS_HIGH_OFS;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_ts_reg <= 64'h0;
      tx_lock_reg <= 1'b0;
    end else begin
      if (tx_cap) begin
        tx_ts_reg <= system_time_value_reg;
      end
      // Capture wins over a release in the same cycle
      if (tx_cap) begin
        tx_lock_reg <= 1'b1;
      end else if (tx_rel) begin
        tx_lock_reg <= 1'b0;
      end
    end
  end

  // Rx parse: time taken at frame start, header bytes collected
  logic rx_udp_ptp;
  assign rx_udp_ptp = (rx_udp_port_i == PTS_UDP_EVENT_PORT) || (rx_udp_port_i == PTS_UDP_GENERAL_PORT);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sof_time_reg <= 64'h0;
      rx_pos_reg <= 6'h0;
      rx_is_ptp_reg <= 1'b0;
      rx_l2_reg <= 1'b0;
      rx_v2_reg <= 1'b0;
      rx_msgid_reg <= 8'h0;
      rx_ctrl_reg <= 8'h0;
      rx_src_cap_reg <= 48'h0;
      rx_seq_cap_reg <= 16'h0;
    end else if (rx_sof_i) begin
      rx_sof_time_reg <= system_time_value_reg;
      rx_pos_reg <= 6'h0;
      rx_is_ptp_reg <= rx_l2_ptp_i || rx_udp_ptp;
      rx_l2_reg <= rx_l2_ptp_i;
    end else if (rx_byte_valid_i && rx_pos_reg <= PTS_HDR_CTRL_OFS) begin
      rx_pos_reg <= rx_pos_reg + 6'h01;
      if (rx_pos_reg == PTS_HDR_MSGID_OFS) begin
        rx_msgid_reg <= rx_byte_i;
      end
      if (rx_pos_reg == PTS_HDR_VER_OFS) begin
        rx_v2_reg <= (rx_byte_i[3:0] == 4'h2);
      end
      if (rx_pos_reg >= PTS_HDR_SRC_FIRST && rx_pos_reg < PTS_HDR_SEQ_HI) begin
        rx_src_cap_reg <= {rx_src_cap_reg[39:0], rx_byte_i};
      end
      if (rx_pos_reg == PTS_HDR_SEQ_HI || rx_pos_reg == PTS_HDR_SEQ_LO) begin
        rx_seq_cap_reg <= {rx_seq_cap_reg[7:0], rx_byte_i};
      end
      if (rx_pos_reg == PTS_HDR_CTRL_OFS) begin
        rx_ctrl_reg <= rx_byte_i;
      end
    end
  end

  // Message match by version
  logic [7:0] cfg_msg;
  logic rx_match;
  logic rx_hdr_done;
  logic rx_cap;
  logic rx_rel;
  assign cfg_msg = ts_ctrl_reg[PTS_CTL_MSG_LSB +: 8];
  assign rx_hdr_done = rx_pos_reg > PTS_HDR_CTRL_OFS;
  assign rx_match = rx_v2_reg ?
    ((rx_msgid_reg[3:0] == cfg_msg[3:0]) || (ts_ctrl_reg[PTS_CTL_V2] &&
     (rx_msgid_reg[3:0] == PTS_V2_PDLY_REQ || rx_msgid_reg[3:0] == PTS_V2_PDLY_RESP))) :
    (rx_ctrl_reg == cfg_msg);
  assign rx_cap = rx_eof_i && rx_is_ptp_reg && rx_hdr_done && rx_match && rx_en && !rx_lock_reg;
  assign rx_rel = wb_rd && wb_adr_i == PTS_RX_TS_HIGH_OFS;

  // Rx capture registers and lock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_ts_reg <= 64'h0;
      rx_src_reg <= 48'h0;
      rx_seq_reg <= 16'h0;
      rx_lock_reg <= 1'b0;
    end else begin
      if (rx_cap) begin
        rx_ts_reg <= rx_sof_time_reg;
        rx_src_reg <= rx_src_cap_reg;
        rx_seq_reg <= rx_seq_cap_reg;
      end
      if (rx_cap) begin
        rx_lock_reg <= 1'b1;
      end else if (rx_rel) begin
        rx_lock_reg <= 1'b0;
      end
    end
  end

  // Descriptor indications at frame end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_desc_valid_o <= 1'b0;
      rx_ptp_ind_o <= 1'b0;
      rx_packet_kind_field_o <= PTS_KIND_NONE;
      timestamp_taken_bit_o <= 1'b0;
    end else begin
      rx_desc_valid_o <= rx_eof_i;
      rx_ptp_ind_o <= rx_eof_i && rx_is_ptp_reg && rx_l2_reg;
      rx_packet_kind_field_o <= (rx_eof_i && rx_is_ptp_reg && rx_l2_reg) ? PTS_KIND_PTP_L2 : PTS_KIND_NONE;
      timestamp_taken_bit_o <= rx_cap;
    end
  end

  // Bus slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_rd) begin
        unique case (wb_adr_i)
          PTS_TIME_LOW_OFS: wb_dat_o <= system_time_value_reg[31:0];
          PTS_TIME_HIGH_OFS: wb_dat_o <= high_latch_reg;
          PTS_INC_CTRL_OFS: wb_dat_o <= time_increment_control_reg;
          PTS_OFS_LOW_OFS: wb_dat_o <= time_offset_low_reg;
          PTS_TS_CTRL_OFS: wb_dat_o <= ts_ctrl_reg;
          PTS_TX_TS_LOW_OFS: wb_dat_o <= tx_ts_reg[31:0];
          PTS_TX_TS_HIGH_OFS: wb_dat_o <= tx_ts_reg[63:32];
          PTS_RX_TS_LOW_OFS: wb_dat_o <= rx_ts_reg[31:0];
          PTS_RX_TS_HIGH_OFS: wb_dat_o <= rx_ts_reg[63:32];
          PTS_RX_SRC_LOW_OFS: wb_dat_o <= rx_src_reg[31:0];
          PTS_RX_SRC_HIGH_OFS: wb_dat_o <= {rx_src_reg[47:32], rx_seq_reg};
          PTS_STATUS_OFS: wb_dat_o <= {29'h0, ts_active, rx_lock_reg, tx_lock_reg};
          default: wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

  // Checks
  tx_lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_lock_reg && !tx_rel |=> tx_lock_reg && $stable(tx_ts_reg)) else $error("tx stamp changed while locked");
  rx_lock_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_lock_reg && !rx_rel |=> rx_lock_reg && $stable(rx_ts_reg)) else $error("rx stamp changed while locked");
  tx_needs_dup_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(tx_lock_reg) |-> $past(full_duplex_i) && $past(timestamp_request_bit_i)) else $error("tx stamp without cause");
  high_latch_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_rd && wb_adr_i == PTS_TIME_LOW_OFS |=> high_latch_reg == $past(system_time_value_reg[63:32]))
    else $error("high half not latched");
  time_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inc_event && !wb_wr |=> system_time_value_reg == $past(system_time_value_reg) + $past(inc_ext))
    else $error("time did not advance by incvalue");
  time_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !inc_event && !wb_wr |=> $stable(system_time_value_reg)) else $error("time moved without event");
  period_one_a: assert property (@(posedge clk_i) disable iff (rst_i)
    inc_period == 8'h01 |-> inc_event) else $error("period one must fire every cycle");
  kind_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_ptp_ind_o |-> rx_packet_kind_field_o == 4'he ##1 !rx_ptp_ind_o) else $error("ptp kind code wrong");
  udp_no_ind_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_eof_i && !rx_l2_reg |=> !rx_ptp_ind_o) else $error("udp frame flagged as ptp");
  taken_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    timestamp_taken_bit_o |-> rx_lock_reg && rx_ts_reg == $past(rx_sof_time_reg)) else $error("taken without capture");
  reset_clear_a: assert property (@(posedge clk_i)
    rst_i |=> system_time_value_reg == 64'h0 && !tx_lock_reg && !rx_lock_reg) else $error("reset incomplete");
endmodule

// File: pts_mac_model.sv
// MAC datapath model: tx frame starts and rx PTP headers at the PHY edge
module pts_mac_model (
  input wire logic clk_i,
  input wire logic tx_go_i, // Start one tx frame
  input wire logic tx_req_i,
  input wire logic rx_go_i, // Start one rx frame
  input wire logic rx_l2_i,
  input wire logic [15:0] rx_port_i,
  input wire logic [7:0] rx_msgid_i,
  input wire logic [7:0] rx_ver_i,
  input wire logic [15:0] rx_seq_i,
  output logic tx_sof_o,
  output logic req_o,
  output logic rx_sof_o,
  output logic rx_l2_o,
  output logic [15:0] rx_port_o,
  output logic rx_vld_o,
  output logic [7:0] rx_byte_o,
  output logic rx_eof_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  int idx = 99; // Frame step, 99 when idle
  // Header byte; unused offsets carry their own index
  function automatic logic [7:0] hdr(input int i);
    case (i)
      0: return rx_msgid_i;
      1: return rx_ver_i;
      30: return rx_seq_i[15:8];
      31: return rx_seq_i[7:0];
      default: return i[7:0];
    endcase
  endfunction
  // Quiet lines at time zero
  initial begin
    {tx_sof_o, req_o, rx_sof_o, rx_l2_o, rx_vld_o, rx_eof_o} = 6'h00;
    rx_port_o = 16'h0000;
    rx_byte_o = 8'h00;
  end
  assign busy_o = idx < 36; // Covers the end of frame cycle too, not the descriptor valid cycle after it
  // Tx start; qualifier toggles outside starts so stale values never help
  always @(posedge clk_i) begin
    tx_sof_o <= tx_go_i;
    req_o <= tx_go_i ? tx_req_i : ~req_o;
  end
  // Rx frame: start, 34 header bytes, end; idle lines invert
  always @(posedge clk_i) begin
    idx <= rx_go_i ? 0 : (idx < 99 ? idx + 1 : 99);
    rx_sof_o <= rx_go_i;
    rx_l2_o <= rx_go_i ? rx_l2_i : ~rx_l2_o;
    rx_port_o <= rx_go_i ? rx_port_i : ~rx_port_o;
    rx_vld_o <= idx < 34;
    rx_byte_o <= (idx < 34) ? hdr(idx) : ~rx_byte_o;
    rx_eof_o <= idx == 34;
  end
endmodule

// File: tb_pts_stamper.sv
// Self-checking bench for the time sync stamper
module tb_pts_stamper
  import pts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic full_duplex_i = 1'b1, tx_go = 1'b0, tx_req = 1'b0, rx_go = 1'b0, rx_l2 = 1'b0;
  logic [15:0] rx_port = 16'h0, rx_seq = 16'h0, rx_udp_port_i;
  logic [7:0] rx_msgid = 8'h00, rx_ver = 8'h02, rx_byte_i;
  logic tx_sof_i, timestamp_request_bit_i, rx_sof_i, rx_l2_ptp_i, rx_byte_valid_i, rx_eof_i, busy;
  logic rx_desc_valid_o, rx_ptp_ind_o, timestamp_taken_bit_o;
  logic [3:0] rx_packet_kind_field_o;
  logic [32:0] bus_q[$]; // Expected reads, bit 32 marks a baseline read
  logic [5:0] rx_q[$]; // Expected {ind, kind, taken}
  logic [7:0] pers[3] = '{8'h00, 8'h01, 8'h03}; // 0 behaves as 1
  logic [31:0] seed = 32'd61639, last, t0, v, th, tl;
  int n_mismatch = 0, checks = 0, cycles = 0;
  initial forever #25 clk_i = ~clk_i;
  pts_stamper i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .full_duplex_i(full_duplex_i), .tx_sof_i(tx_sof_i),
    .timestamp_request_bit_i(timestamp_request_bit_i), .rx_sof_i(rx_sof_i), .rx_l2_ptp_i(rx_l2_ptp_i),
    .rx_udp_port_i(rx_udp_port_i), .rx_byte_valid_i(rx_byte_valid_i), .rx_byte_i(rx_byte_i),
    .rx_eof_i(rx_eof_i), .rx_desc_valid_o(rx_desc_valid_o), .rx_ptp_ind_o(rx_ptp_ind_o),
    .rx_packet_kind_field_o(rx_packet_kind_field_o), .timestamp_taken_bit_o(timestamp_taken_bit_o));
  pts_mac_model i_mac (.clk_i(clk_i), .tx_go_i(tx_go), .tx_req_i(tx_req), .rx_go_i(rx_go), .rx_l2_i(rx_l2),
    .rx_port_i(rx_port), .rx_msgid_i(rx_msgid), .rx_ver_i(rx_ver), .rx_seq_i(rx_seq), .tx_sof_o(tx_sof_i),
    .req_o(timestamp_request_bit_i), .rx_sof_o(rx_sof_i), .rx_l2_o(rx_l2_ptp_i), .rx_port_o(rx_udp_port_i),
    .rx_vld_o(rx_byte_valid_i), .rx_byte_o(rx_byte_i), .rx_eof_o(rx_eof_i), .busy_o(busy));
  // Xorshift source for increments and time values
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Classic cycle; held until ack is sampled, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // No local limit: only the hang guard may end this wait
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    last = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus_q.push_back({1'b0, e});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic rdx(input logic [7:0] a);
    bus_q.push_back({1'b1, 32'h0});
    bus(1'b0, a, 32'h0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  // One tx frame start; lock lands within the wait
  task automatic tx(input logic r);
    tx_req <= r;
    tx_go <= 1'b1;
    @(posedge clk_i);
    tx_go <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask
  // One rx frame with its expected descriptor bits
  task automatic frame(input logic l2, input logic [15:0] p, input logic [7:0] m, input logic [7:0] ver,
                       input logic [5:0] e);
    int n;
    n = 0;
    rx_q.push_back(e);
    rx_l2 <= l2;
    rx_port <= p;
    rx_msgid <= m;
    rx_ver <= ver;
    rx_seq <= 16'(xs());
    rx_go <= 1'b1;
    @(posedge clk_i);
    rx_go <= 1'b0;
    repeat (2) @(posedge clk_i);
    while (busy === 1'b1 && n < 60) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  task automatic cmp_bus(input logic [32:0] e);
    if (e[32] === 1'b1) return;
    checks++;
    if (wb_dat_o !== e[31:0]) begin
      n_mismatch++;
      $display("Error at %0t: read %h expected %h", $time, wb_dat_o, e[31:0]);
    end
  endtask
  task automatic cmp_rx(input logic [5:0] e);
    checks++;
    if ({rx_ptp_ind_o, rx_packet_kind_field_o, timestamp_taken_bit_o} !== e) begin
      n_mismatch++;
      $display("Error at %0t: rx %h expected %h", $time,
               {rx_ptp_ind_o, rx_packet_kind_field_o, timestamp_taken_bit_o}, e);
    end
  endtask
  task automatic print_verdict();
    // Notes never matched by a result count as misses
    if (bus_q.size() != 0 || rx_q.size() != 0) n_mismatch++;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watch outputs; oldest note is compared when a result appears
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (bus_q.size() == 0) begin
        n_mismatch++;
        $display("Error at %0t: read %h expected %h", $time, wb_dat_o, 32'h0);
      end else cmp_bus(bus_q.pop_front());
    end
    if (rx_desc_valid_o === 1'b1) begin
      if (rx_q.size() == 0) begin
        n_mismatch++;
        $display("Error at %0t: rx %h expected %h", $time, rx_packet_kind_field_o, 4'h0);
      end else cmp_rx(rx_q.pop_front());
    end
  end
  // Hang guard, well above the roughly 500 cycles needed
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(PTS_INC_CTRL_OFS, PTS_INC_CTRL_RST);
    rd(PTS_TIME_LOW_OFS, 32'h0);
    rd(PTS_STATUS_OFS, 32'h1 << PTS_ST_ACTIVE);
    rd(8'h3c, 32'h0);
    $display("test reset done");
    wr(PTS_TIME_HIGH_OFS, 32'h11);
    rd(PTS_TIME_LOW_OFS, 32'h0);
    wr(PTS_TIME_HIGH_OFS, 32'h22);
    rd(PTS_TIME_HIGH_OFS, 32'h11);
    rd(PTS_TIME_LOW_OFS, 32'h0);
    rd(PTS_TIME_HIGH_OFS, 32'h22);
    wr(PTS_TIME_HIGH_OFS, 32'hffff_ffff);
    wr(PTS_TIME_LOW_OFS, 32'hffff_ffff);
    wr(PTS_OFS_LOW_OFS, 32'h2);
    wr(PTS_OFS_HIGH_OFS, 32'h0);
    rd(PTS_TIME_LOW_OFS, 32'h1);
    rd(PTS_TIME_HIGH_OFS, 32'h0);
    wr(PTS_OFS_LOW_OFS, 32'h2);
    wr(PTS_OFS_HIGH_OFS, 32'h8000_0000);
    rd(PTS_TIME_LOW_OFS, 32'hffff_ffff);
    rd(PTS_TIME_HIGH_OFS, 32'hffff_ffff);
    $display("test time done");
    // Reads are three cycles apart: period 3 gives one event
    foreach (pers[i]) begin
      v = xs() & 32'h00ff_ffff;
      wr(PTS_INC_CTRL_OFS, {pers[i], v[23:0]});
      rdx(PTS_TIME_LOW_OFS);
      t0 = last;
      rd(PTS_TIME_LOW_OFS, t0 + ((pers[i] == 8'h03) ? v : 32'h3 * v));
    end
    wr(PTS_INC_CTRL_OFS, PTS_INC_CTRL_RST);
    th = xs();
    tl = xs();
    wr(PTS_TIME_HIGH_OFS, th);
    wr(PTS_TIME_LOW_OFS, tl);
    $display("test increment done");
    wr(PTS_TS_CTRL_OFS, 32'h0000_0007);
    tx(1'b1);
    rd(PTS_STATUS_OFS, 32'h5);
    wr(PTS_TIME_LOW_OFS, tl + 32'h1);
    tx(1'b1);
    rd(PTS_TX_TS_LOW_OFS, tl);
    rd(PTS_TX_TS_HIGH_OFS, th);
    tx(1'b0);
    rd(PTS_STATUS_OFS, 32'h4);
    wr(PTS_TS_CTRL_OFS, 32'h0000_0006);
    tx(1'b1);
    rd(PTS_STATUS_OFS, 32'h4);
    full_duplex_i <= 1'b0;
    wr(PTS_TS_CTRL_OFS, 32'h0000_0007);
    tx(1'b1);
    rd(PTS_STATUS_OFS, 32'h0);
    full_duplex_i <= 1'b1;
    $display("test tx done");
    frame(1'b1, 16'h0, 8'h00, 8'h02, {1'b1, PTS_KIND_PTP_L2, 1'b1});
    rd(PTS_RX_TS_LOW_OFS, tl + 32'h1);
    rd(PTS_RX_SRC_LOW_OFS, 32'h1a1b_1c1d);
    rd(PTS_RX_SRC_HIGH_OFS, {16'h1819, rx_seq});
    frame(1'b1, 16'h0, 8'h00, 8'h02, {1'b1, PTS_KIND_PTP_L2, 1'b0});
    rd(PTS_RX_TS_HIGH_OFS, th);
    frame(1'b1, 16'h0, 8'h08, 8'h02, {1'b1, PTS_KIND_PTP_L2, 1'b0});
    frame(1'b0, 16'h0, 8'h00, 8'h02, {1'b0, PTS_KIND_NONE, 1'b0});
    frame(1'b0, PTS_UDP_EVENT_PORT, 8'h00, 8'h02, {1'b0, PTS_KIND_NONE, 1'b1});
    rd(PTS_RX_TS_HIGH_OFS, th);
    frame(1'b0, PTS_UDP_GENERAL_PORT, 8'h02, 8'h02, {1'b0, PTS_KIND_NONE, 1'b1});
    rd(PTS_RX_TS_HIGH_OFS, th);
    wr(PTS_TS_CTRL_OFS, 32'h0000_2003);
    frame(1'b1, 16'h0, 8'h05, 8'h01, {1'b1, PTS_KIND_PTP_L2, 1'b1});
    $display("test rx done");
    // Both stamps locked, then a mid-run reset must clear them
    tx(1'b1);
    rd(PTS_STATUS_OFS, 32'h7);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(PTS_STATUS_OFS, 32'h1 << PTS_ST_ACTIVE);
    rd(PTS_TX_TS_LOW_OFS, 32'h0);
    rd(PTS_RX_SRC_HIGH_OFS, 32'h0);
    rd(PTS_TS_CTRL_OFS, 32'h0);
    $display("test mid reset done");
    // Let the last results reach the watcher
    repeat (4) @(posedge clk_i);
    print_verdict();
  end
endmodule
